/* File: dv/ack_props_properties.sv */
// port-level checker for link numbering, acknowledgement and bus answer timing
`timescale 1ns/1ns
module ack_props #(parameter DATA_W = 32) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire tx_valid,
    input wire tx_ready,
    input wire rx_valid,
    input wire [DATA_W-1:0] rx_data,
    input wire lk_tx_valid,
    input wire [9:0] lk_tx_seq,
    input wire [9:0] lk_tx_ack,
    input wire lk_tx_ack_valid,
    input wire lk_tx_lp,
    input wire lk_tx_ctl,
    input wire lk_tx_ready,
    input wire lk_rx_valid,
    input wire lk_rx_lp,
    input wire lk_rx_ctl,
    input wire [DATA_W-1:0] lk_rx_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire acc = lk_tx_valid && lk_tx_ready;
    reg pa_v;
    reg [9:0] pa_seq;
    reg got_rx;
    // remember the last accepted pure ack; a data or control packet in between clears it, as numbering may move then
    always @(posedge clk) begin
        if (sys_rst) begin
            pa_v <= 1'h0;
            got_rx <= 1'h0;
        end else begin
            if (lk_rx_valid && (lk_rx_lp || lk_rx_ctl))
                got_rx <= 1'h1;
            if (acc)
                pa_v <= !(lk_tx_lp || lk_tx_ctl);
            if (acc)
                pa_seq <= lk_tx_seq;
        end
    end
    a_ack_returned: assert property (lk_rx_valid && lk_rx_lp |-> ##[1:200] (lk_tx_valid && lk_tx_ack_valid))
        else $error("received packet not acknowledged");
    a_pure_ack_seq: assert property (acc && !lk_tx_lp && !lk_tx_ctl && pa_v |-> lk_tx_seq == pa_seq)
        else $error("pure ack moved the sequence number");
    a_seq_range: assert property (lk_tx_valid |-> lk_tx_seq <= 10'h3E7 && lk_tx_ack <= 10'h3E7)
        else $error("number outside three-digit range");
    a_rx_delivery: assert property (rx_valid |-> $past(lk_rx_valid && lk_rx_lp) && rx_data == $past(lk_rx_data))
        else $error("delivery without matching arrival");
    a_ack_valid_init: assert property (lk_tx_valid && !got_rx |-> !lk_tx_ack_valid)
        else $error("ack marked valid before any reception");
    a_tx_goes_out: assert property (tx_valid && tx_ready |-> ##[1:300] (acc && lk_tx_lp))
        else $error("taken packet never sent");
    a_link_hold: assert property (lk_tx_valid && !lk_tx_ready |=> lk_tx_valid && $stable(lk_tx_seq) && $stable(lk_tx_lp))
        else $error("link packet changed before taken");
    a_ctl_no_lp: assert property (lk_tx_valid |-> !(lk_tx_lp && lk_tx_ctl))
        else $error("control packet carries a logical packet");
    a_bus_answer: assert property (pready |-> $past(psel && !penable) ##1 !pready)
        else $error("bus answer not one cycle after setup");
    c_ctl: cover property (acc && lk_tx_ctl);
    c_pure: cover property (acc && !lk_tx_lp && !lk_tx_ctl);
    c_data: cover property (acc && lk_tx_lp && lk_tx_ack_valid);
endmodule // ack_props

/* File: dv/far_entity.sv */
// behavioural remote transport entity: takes link packets into a log, sends commanded ones
`timescale 1ns/1ns
module far_entity (
    input wire clk,
    input wire sys_rst,
    input wire slow,
    input wire lk_tx_valid,
    input wire [9:0] lk_tx_seq,
    input wire [9:0] lk_tx_ack,
    input wire lk_tx_ack_valid,
    input wire lk_tx_lp,
    input wire lk_tx_ctl,
    input wire [31:0] lk_tx_data,
    output reg lk_tx_ready,
    output reg lk_rx_valid,
    output reg [9:0] lk_rx_seq,
    output reg [9:0] lk_rx_ack,
    output reg lk_rx_ack_valid,
    output reg lk_rx_lp,
    output reg lk_rx_ctl,
    output reg [31:0] lk_rx_data
);
    reg [9:0] seq_log [0:127];
    reg [9:0] ack_log [0:127];
    reg [2:0] flg_log [0:127];
    reg [31:0] dat_log [0:127];
    integer n_seen = 0;
    initial begin
        lk_tx_ready = 1'h0;
        lk_rx_valid = 1'h0;
        {lk_rx_seq, lk_rx_ack, lk_rx_ack_valid, lk_rx_lp, lk_rx_ctl, lk_rx_data} = 55'h0;
    end
    // slow mode accepts every other cycle only, so the sender has to hold its packet
    always @(posedge clk) begin
        lk_tx_ready <= sys_rst ? 1'h0 : (slow ? ~lk_tx_ready : 1'h1);
        if (lk_tx_valid && lk_tx_ready) begin
            seq_log[n_seen] <= lk_tx_seq;
            ack_log[n_seen] <= lk_tx_ack;
            flg_log[n_seen] <= {lk_tx_ack_valid, lk_tx_lp, lk_tx_ctl};
            dat_log[n_seen] <= lk_tx_data;
            n_seen <= n_seen + 1;
        end
    end
    // one packet for one cycle; afterwards seq, ack, lp and data show the inverse, the ack valid and ctl lines keep theirs
    task send(input [9:0] s, input [9:0] a, input lp, input [31:0] d);
        begin
            @(posedge clk);
            lk_rx_valid <= 1'h1;
            {lk_rx_seq, lk_rx_ack, lk_rx_ack_valid, lk_rx_lp, lk_rx_ctl, lk_rx_data} <= {s, a, 1'h1, lp, 1'h0, d};
            @(posedge clk);
            lk_rx_valid <= 1'h0;
            {lk_rx_seq, lk_rx_ack, lk_rx_lp, lk_rx_data} <= ~{s, a, lp, d};
        end
    endtask
endmodule // far_entity

/* File: dv/testbench.sv */
// bench: register bus, numbering, loss, time-out, duplicate, gap and interrupt scenarios
`timescale 1ns/1ns
`include "transport_defines.vh"
module testbench;
    reg clk = 1'h0;
    reg sys_rst = 1'h1;
    reg ce = 1'h1;
    reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0, tx_valid = 1'h0, slow = 1'h0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, tx_data = 32'h0, rx_last = 32'h0, rd;
    reg er;
    wire [31:0] prdata, rx_data, lk_tx_data, lk_rx_data;
    wire pready, pslverr, irq, tx_ready, rx_valid, lk_tx_valid, lk_tx_ack_valid, lk_tx_lp, lk_tx_ctl;
    wire lk_tx_ready, lk_rx_valid, lk_rx_ack_valid, lk_rx_lp, lk_rx_ctl;
    wire [9:0] lk_tx_seq, lk_tx_ack, lk_rx_seq, lk_rx_ack;
    integer error_cnt = 0, n_compared = 0, rx_cnt = 0, k;
    initial forever #2 clk = ~clk;
    transport_ack_retransmit u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .lk_tx_valid(lk_tx_valid), .lk_tx_seq(lk_tx_seq), .lk_tx_ack(lk_tx_ack),
        .lk_tx_ack_valid(lk_tx_ack_valid), .lk_tx_lp(lk_tx_lp), .lk_tx_ctl(lk_tx_ctl), .lk_tx_data(lk_tx_data),
        .lk_tx_ready(lk_tx_ready), .lk_rx_valid(lk_rx_valid), .lk_rx_seq(lk_rx_seq), .lk_rx_ack(lk_rx_ack),
        .lk_rx_ack_valid(lk_rx_ack_valid), .lk_rx_lp(lk_rx_lp), .lk_rx_ctl(lk_rx_ctl), .lk_rx_data(lk_rx_data));
    far_entity u_far (.clk(clk), .sys_rst(sys_rst), .slow(slow), .lk_tx_valid(lk_tx_valid), .lk_tx_seq(lk_tx_seq),
        .lk_tx_ack(lk_tx_ack), .lk_tx_ack_valid(lk_tx_ack_valid), .lk_tx_lp(lk_tx_lp), .lk_tx_ctl(lk_tx_ctl),
        .lk_tx_data(lk_tx_data),
        .lk_tx_ready(lk_tx_ready), .lk_rx_valid(lk_rx_valid), .lk_rx_seq(lk_rx_seq), .lk_rx_ack(lk_rx_ack),
        .lk_rx_ack_valid(lk_rx_ack_valid), .lk_rx_lp(lk_rx_lp), .lk_rx_ctl(lk_rx_ctl), .lk_rx_data(lk_rx_data));
    // count delivered logical packets
    always @(posedge clk) begin
        if (rx_valid) begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= rx_data;
        end
    end
    task end_of_test;
        begin
            if (error_cnt == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // ack compared only where the packet marks it valid
    task chk_pkt(input integer i, input [9:0] s, input [9:0] a, input [2:0] f);
        begin
            chk({22'h0, u_far.seq_log[i]}, {22'h0, s});
            chk({29'h0, u_far.flg_log[i]}, {29'h0, f});
            if (f[2])
                chk({22'h0, u_far.ack_log[i]}, {22'h0, a});
        end
    endtask
    // request held until pready is seen high at an edge; only the watchdog ends a wait
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
            @(posedge clk);
            penable <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1) begin
                @(posedge clk);
            end
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask
    task take_tx;
        begin
            @(posedge clk);
            while (tx_ready !== 1'h1) begin
                @(posedge clk);
            end
            tx_valid <= 1'h0;
        end
    endtask
    task put_tx(input [31:0] d);
        begin
            @(posedge clk);
            {tx_valid, tx_data} <= {1'h1, d};
            take_tx;
        end
    endtask
    task wait_log(input integer m);
        begin
            while (u_far.n_seen < m) begin
                @(posedge clk);
            end
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        apb(1'h0, `OFF_TIMEOUT, 32'h0);
        chk(rd, 32'h3E8);
        apb(1'h0, 12'hFFC, 32'h0);
        chk({31'h0, er}, 32'h1);
        // offer while closed: nothing may reach the link
        {tx_valid, tx_data} <= {1'h1, 32'hA0};
        repeat (20) @(posedge clk);
        chk(u_far.n_seen, 32'h0);
        apb(1'h1, `OFF_INIT, 32'h3E6);
        apb(1'h1, `OFF_INT_EN, 32'h1F);
        apb(1'h1, `OFF_CTRL, 32'h1);
        take_tx;
        put_tx(32'hA1);
        put_tx(32'hA2);
        wait_log(3);
        chk_pkt(0, 10'h3E6, 10'h0, 3'h2);
        chk_pkt(1, 10'h3E7, 10'h0, 3'h2);
        chk_pkt(2, 10'h000, 10'h0, 3'h2);
        // peer acks only the first: the run from the lost one is sent again with a fresh ack
        u_far.send(10'h200, 10'h3E7, 1'h1, 32'hB0);
        wait_log(5);
        chk_pkt(3, 10'h3E7, 10'h201, 3'h6);
        chk_pkt(4, 10'h000, 10'h201, 3'h6);
        chk(u_far.dat_log[3], 32'hA1);
        chk(u_far.dat_log[4], 32'hA2);
        chk(rx_last, 32'hB0);
        apb(1'h0, `OFF_INT_STAT, 32'h0);
        chk(rd, 32'h12);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, `OFF_INT_EN, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, `OFF_INT_CLR, 32'h1F);
        apb(1'h1, `OFF_INT_EN, 32'h1F);
        apb(1'h0, `OFF_INT_STAT, 32'h0);
        chk(rd, 32'h0);
        // all acked and nothing to send: a pure ack repeating the last data number
        k = u_far.n_seen;
        u_far.send(10'h201, 10'h001, 1'h1, 32'hC0);
        wait_log(k + 1);
        chk_pkt(k, 10'h000, 10'h202, 3'h4);
        u_far.send(10'h202, 10'h001, 1'h1, 32'hC1);
        u_far.send(10'h203, 10'h001, 1'h1, 32'hC2);
        repeat (30) @(posedge clk);
        chk({22'h0, u_far.ack_log[u_far.n_seen - 1]}, 32'h204);
        // duplicate then gap: both dropped, ack stays at the last in-order one
        k = u_far.n_seen;
        u_far.send(10'h202, 10'h001, 1'h1, 32'hD0);
        u_far.send(10'h206, 10'h001, 1'h1, 32'hD1);
        repeat (30) @(posedge clk);
        chk(rx_cnt, 32'h4);
        chk(rx_last, 32'hC2);
        chk({31'h0, u_far.n_seen > k}, 32'h1);
        chk({22'h0, u_far.ack_log[u_far.n_seen - 1]}, 32'h204);
        apb(1'h0, `OFF_INT_STAT, 32'h0);
        chk(rd, 32'h19);
        apb(1'h0, `OFF_STATUS, 32'h0);
        chk(rd, 32'h0A040001);
        // no ack from a slow peer: resent from the oldest after the short time-out
        apb(1'h1, `OFF_TIMEOUT, 32'h14);
        slow <= 1'h1;
        k = u_far.n_seen;
        put_tx(32'hE0);
        wait_log(k + 2);
        chk_pkt(k, 10'h001, 10'h204, 3'h6);
        chk_pkt(k + 1, 10'h001, 10'h204, 3'h6);
        chk(u_far.dat_log[k + 1], 32'hE0);
        apb(1'h0, `OFF_INT_STAT, 32'h0);
        chk(rd & 32'h4, 32'h4);
        u_far.send(10'h203, 10'h002, 1'h0, 32'h0);
        slow <= 1'h0;
        repeat (30) @(posedge clk);
        // a control packet takes a number of its own
        k = u_far.n_seen;
        apb(1'h1, `OFF_CTRL, 32'h3);
        wait_log(k + 1);
        chk_pkt(k, 10'h002, 10'h204, 3'h5);
        u_far.send(10'h203, 10'h003, 1'h0, 32'h0);
        end_of_test;
    end
    // cut a hang short well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        end_of_test;
    end
endmodule // testbench
bind transport_ack_retransmit ack_props #(.DATA_W(DATA_W)) u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pready(pready), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .lk_tx_valid(lk_tx_valid), .lk_tx_seq(lk_tx_seq), .lk_tx_ack(lk_tx_ack),
    .lk_tx_ack_valid(lk_tx_ack_valid), .lk_tx_lp(lk_tx_lp), .lk_tx_ctl(lk_tx_ctl), .lk_tx_ready(lk_tx_ready),
    .lk_rx_valid(lk_rx_valid), .lk_rx_lp(lk_rx_lp), .lk_rx_ctl(lk_rx_ctl), .lk_rx_data(lk_rx_data));

/* File: hw/rto_timer.v */
// retransmission time-out counter, one pulse when the limit is reached
`timescale 1ns/1ns
module rto_timer #(
    parameter W = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire run,
    input wire restart,
    input wire [W-1:0] limit,
    output reg expired
);
    reg [W-1:0] cnt_r;

    // a limit of zero behaves as one cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= {W{1'b0}};
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (restart || !run) begin
                cnt_r <= {W{1'b0}};
            end else if (cnt_r + {{(W-1){1'b0}}, 1'b1} >= limit) begin
                cnt_r <= {W{1'b0}};
                expired <= 1'b1;
            end else begin
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // rto_timer

/* File: hw/transport_ack_retransmit.v */
// transport entity: numbering, cumulative acknowledgement, loss detection and retransmission
`timescale 1ns/1ns
`include "transport_defines.vh"

module transport_ack_retransmit #(
    parameter DATA_W = 32,
    parameter DEPTH = 8,
    parameter TMO_W = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire tx_valid,
    input wire [DATA_W-1:0] tx_data,
    output reg tx_ready,
    output reg rx_valid,
    output reg [DATA_W-1:0] rx_data,
    output reg lk_tx_valid,
    output reg [9:0] lk_tx_seq,
    output reg [9:0] lk_tx_ack,
    output reg lk_tx_ack_valid,
    output reg lk_tx_lp,
    output reg lk_tx_ctl,
    output reg [DATA_W-1:0] lk_tx_data,
    input wire lk_tx_ready,
    input wire lk_rx_valid,
    input wire [9:0] lk_rx_seq,
    input wire [9:0] lk_rx_ack,
    input wire lk_rx_ack_valid,
    input wire lk_rx_lp,
    input wire lk_rx_ctl,
    input wire [DATA_W-1:0] lk_rx_data
);
    localparam SW = DATA_W + 2;
    localparam [9:0] WIN_MAX = DEPTH - 1;
    localparam [TMO_W-1:0] TMO_RST = `RTO_CYCLES;

    // successor with wrap from 999 to 000
    function [9:0] seq_inc(input [9:0] s);
        begin
            seq_inc = (s == `SEQ_LAST) ? 10'h000 : s + 10'h001;
        end
    endfunction

    function [9:0] seq_dec(input [9:0] s);
        begin
            seq_dec = (s == 10'h000) ? `SEQ_LAST : s - 10'h001;
        end
    endfunction

    // forward distance from a to b modulo 1000; mod-1024 wrap of the sum is harmless
    function [9:0] seq_dist(input [9:0] a, input [9:0] b);
        begin
            seq_dist = (b >= a) ? b - a : b + `SEQ_MOD - a;
        end
    endfunction

    function reg_hit(input [11:0] a);
        begin
            reg_hit = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_INT_STAT) || (a == `OFF_INT_EN) ||
                      (a == `OFF_INT_CLR) || (a == `OFF_TIMEOUT) || (a == `OFF_INIT);
        end
    endfunction

    reg open_r, open_nxt, ctl_pend_r, ctl_pend_nxt, ackv_r, ackv_nxt, ack_pend_r, ack_pend_nxt;
    reg [9:0] una_r, una_nxt, sptr_r, sptr_nxt, wptr_r, wptr_nxt, rcv_r, rcv_nxt, last_r, last_nxt;
    reg [9:0] init_r, init_nxt;
    reg [`EV_W-1:0] stat_r, stat_nxt, en_r, en_nxt;
    reg [TMO_W-1:0] tmo_r, tmo_nxt;
    reg [31:0] rd_mux;
    wire [SW-1:0] rd_word;
    wire expired;

    // link handshake, bus phases
    wire lk_free = ~lk_tx_valid | lk_tx_ready;
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pready & pwrite;

    // receive side classification; nothing is taken while closed
    wire rx_on = lk_rx_valid & open_r;
    wire carries = lk_rx_lp | lk_rx_ctl;
    wire [9:0] sent_cnt = seq_dist(una_r, sptr_r);
    wire [9:0] ack_d = seq_dist(una_r, lk_rx_ack);
    wire ack_ok = rx_on & lk_rx_ack_valid & (ack_d <= sent_cnt);
    wire loss = ack_ok & (lk_rx_ack != sptr_r);
    wire in_seq = rx_on & carries & (~ackv_r | (lk_rx_seq == rcv_r));
    wire [9:0] back_d = seq_dist(lk_rx_seq, rcv_r);
    wire dup = rx_on & carries & ~in_seq & (back_d < `SEQ_HALF);
    wire gap = rx_on & carries & ~in_seq & ~dup;
    wire [`EV_W-1:0] ev = {in_seq & lk_rx_lp, dup, expired & ~loss, loss, gap};

    // transmit side: the user and control packets fill the store, the send pointer drains it
    wire take = tx_valid & tx_ready;
    wire wr_ctl = ctl_pend_r & open_r & ~take;
    wire st_wr = take | wr_ctl;
    wire send_data = open_r & lk_free & (sptr_r != wptr_r);
    wire send_ack = open_r & lk_free & ~send_data & ack_pend_r;
    wire timer_run = open_r & (sent_cnt != 10'h000);
    wire timer_restart = (una_nxt != una_r) | (send_data & (sent_cnt == 10'h000)) | loss;

    tx_store #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH)
    ) u_store (
        .clk(clk),
        .ce(ce),
        .wr_en(st_wr),
        .wr_seq(wptr_r),
        .wr_word({take, wr_ctl, take ? tx_data : {DATA_W{1'b0}}}),
        .rd_seq(sptr_r),
        .rd_word(rd_word)
    );

    rto_timer #(
        .W(TMO_W)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(timer_run),
        .restart(timer_restart),
        .limit(tmo_r),
        .expired(expired)
    );

    // next state of the protocol and the register file
    always @* begin
        open_nxt = open_r;
        ctl_pend_nxt = ctl_pend_r;
        ackv_nxt = ackv_r;
        ack_pend_nxt = ack_pend_r;
        una_nxt = una_r;
        sptr_nxt = sptr_r;
        wptr_nxt = wptr_r;
        rcv_nxt = rcv_r;
        last_nxt = last_r;
        init_nxt = init_r;
        en_nxt = en_r;
        tmo_nxt = tmo_r;
        stat_nxt = stat_r;
        if (ack_ok) begin
            una_nxt = lk_rx_ack;
        end
        // loss rewinds to the first unacknowledged, time-out to the oldest outstanding
        if (loss) begin
            sptr_nxt = lk_rx_ack;
        end else if (expired) begin
            sptr_nxt = una_r;
        end else if (send_data) begin
            sptr_nxt = seq_inc(sptr_r);
        end
        if (send_data) begin
            last_nxt = sptr_r;
        end
        if (st_wr) begin
            wptr_nxt = seq_inc(wptr_r);
        end
        if (wr_ctl) begin
            ctl_pend_nxt = 1'b0;
        end
        if (send_data || send_ack) begin
            ack_pend_nxt = 1'b0;
        end
        // a fresh arrival wins over the clear by a send in the same cycle
        if (rx_on && carries) begin
            ack_pend_nxt = 1'b1;
            ackv_nxt = 1'b1;
        end
        if (in_seq) begin
            rcv_nxt = seq_inc(lk_rx_seq);
        end
        if (wr_acc) begin
            if (paddr == `OFF_CTRL) begin
                open_nxt = pwdata[`CTRL_OPEN];
                if (pwdata[`CTRL_SEND] && open_r) begin
                    ctl_pend_nxt = 1'b1;
                end
            end else if (paddr == `OFF_INT_EN) begin
                en_nxt = pwdata[`EV_W-1:0];
            end else if (paddr == `OFF_INT_CLR) begin
                stat_nxt = stat_r & ~pwdata[`EV_W-1:0];
            end else if (paddr == `OFF_TIMEOUT) begin
                tmo_nxt = pwdata[TMO_W-1:0];
            end else if (paddr == `OFF_INIT) begin
                init_nxt = pwdata[9:0];
            end
        end
        stat_nxt = stat_nxt | ev;
        // opening reloads numbering; acknowledgements are invalid until the peer is heard
        if (open_nxt && !open_r) begin
            una_nxt = init_r;
            sptr_nxt = init_r;
            wptr_nxt = init_r;
            last_nxt = seq_dec(init_r);
            rcv_nxt = 10'h000;
            ackv_nxt = 1'b0;
            ack_pend_nxt = 1'b0;
            ctl_pend_nxt = 1'b0;
        end
    end

    // register read data
    always @* begin
        rd_mux = 32'h00000000;
        if (paddr == `OFF_CTRL) begin
            rd_mux[`CTRL_OPEN] = open_r;
            rd_mux[`CTRL_SEND] = ctl_pend_r;
        end else if (paddr == `OFF_STATUS) begin
            rd_mux[`STAT_TXSEQ_LSB +: 10] = wptr_r;
            rd_mux[`STAT_RXEXP_LSB +: 10] = rcv_r;
            rd_mux[`STAT_RTX_BIT] = (sptr_r != wptr_r) && (sent_cnt != 10'h000);
            rd_mux[`STAT_ACKV_BIT] = ackv_r;
            rd_mux[`STAT_OUT_LSB +: 4] = sent_cnt[3:0];
        end else if (paddr == `OFF_INT_STAT) begin
            rd_mux[`EV_W-1:0] = stat_r;
        end else if (paddr == `OFF_INT_EN) begin
            rd_mux[`EV_W-1:0] = en_r;
        end else if (paddr == `OFF_TIMEOUT) begin
            rd_mux[TMO_W-1:0] = tmo_r;
        end else if (paddr == `OFF_INIT) begin
            rd_mux[9:0] = init_r;
        end
    end

    // state registers, bus answer and link outputs; all frozen while ce is low
    always @(posedge clk) begin
        if (sys_rst) begin
            open_r <= 1'b0;
            ctl_pend_r <= 1'b0;
            ackv_r <= 1'b0;
            ack_pend_r <= 1'b0;
            una_r <= 10'h000;
            sptr_r <= 10'h000;
            wptr_r <= 10'h000;
            rcv_r <= 10'h000;
            last_r <= 10'h000;
            init_r <= 10'h000;
            en_r <= {`EV_W{1'b0}};
            stat_r <= {`EV_W{1'b0}};
            tmo_r <= TMO_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= {DATA_W{1'b0}};
            lk_tx_valid <= 1'b0;
            lk_tx_seq <= 10'h000;
            lk_tx_ack <= 10'h000;
            lk_tx_ack_valid <= 1'b0;
            lk_tx_lp <= 1'b0;
            lk_tx_ctl <= 1'b0;
            lk_tx_data <= {DATA_W{1'b0}};
        end else if (ce) begin
            open_r <= open_nxt;
            ctl_pend_r <= ctl_pend_nxt;
            ackv_r <= ackv_nxt;
            ack_pend_r <= ack_pend_nxt;
            una_r <= una_nxt;
            sptr_r <= sptr_nxt;
            wptr_r <= wptr_nxt;
            rcv_r <= rcv_nxt;
            last_r <= last_nxt;
            init_r <= init_nxt;
            en_r <= en_nxt;
            stat_r <= stat_nxt;
            tmo_r <= tmo_nxt;
            // no wait state: answer is ready in the first access cycle
            pready <= setup;
            pslverr <= setup & ~reg_hit(paddr);
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end
            irq <= |(stat_nxt & en_nxt);
            // window kept one below depth for user packets only; control packets are stored without this check and can make stored numbers alias
            tx_ready <= open_nxt & open_r & ~ctl_pend_nxt & (seq_dist(una_nxt, wptr_nxt) < WIN_MAX);
            // in-order packets only go up; gaps and duplicates are dropped
            rx_valid <= in_seq & lk_rx_lp;
            if (in_seq && lk_rx_lp) begin
                rx_data <= lk_rx_data;
            end
            if (send_data) begin
                lk_tx_valid <= 1'b1;
                lk_tx_seq <= sptr_r;
                lk_tx_ack <= rcv_r;
                lk_tx_ack_valid <= ackv_r;
                lk_tx_lp <= rd_word[SW-1];
                lk_tx_ctl <= rd_word[SW-2];
                lk_tx_data <= rd_word[DATA_W-1:0];
            end else if (send_ack) begin
                lk_tx_valid <= 1'b1;
                lk_tx_seq <= last_r;
                lk_tx_ack <= rcv_r;
                lk_tx_ack_valid <= ackv_r;
                lk_tx_lp <= 1'b0;
                lk_tx_ctl <= 1'b0;
                lk_tx_data <= {DATA_W{1'b0}};
            end else if (lk_tx_ready) begin
                lk_tx_valid <= 1'b0;
            end
        end
    end
endmodule // transport_ack_retransmit

/* File: hw/tx_store.v */
// store of sent packets kept until acknowledged, indexed by sequence number
`timescale 1ns/1ns
module tx_store #(
    parameter DATA_W = 32,
    parameter DEPTH = 8
) (
    input wire clk,
    input wire ce,
    input wire wr_en,
    input wire [9:0] wr_seq,
    input wire [DATA_W+1:0] wr_word,
    input wire [9:0] rd_seq,
    output wire [DATA_W+1:0] rd_word
);
    localparam AW = $clog2(DEPTH);

    reg [DATA_W+1:0] mem [0:DEPTH-1];

    // depth must be a power of two dividing 1000, so low bits stay unique across the 999 to 000 wrap
    always @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_seq[AW-1:0]] <= wr_word;
        end
    end

    assign rd_word = mem[rd_seq[AW-1:0]];
endmodule // tx_store

/* File: inc/transport_defines.vh */
// constants for the control-channel transport acknowledge and retransmit block
`ifndef TRANSPORT_DEFINES_VH
`define TRANSPORT_DEFINES_VH

// three-digit sequence numbering, 000..999
`define SEQ_W 10
`define SEQ_MOD 10'h3E8
`define SEQ_LAST 10'h3E7
`define SEQ_HALF 10'h1F4

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_INT_STAT 12'h008
`define OFF_INT_EN 12'h00C
`define OFF_INT_CLR 12'h010
`define OFF_TIMEOUT 12'h014
`define OFF_INIT 12'h018

// control register bits
`define CTRL_OPEN 0
`define CTRL_SEND 1

// status register fields
`define STAT_TXSEQ_LSB 0
`define STAT_RXEXP_LSB 16
`define STAT_RTX_BIT 26
`define STAT_ACKV_BIT 27
`define STAT_OUT_LSB 28

// event bits of the interrupt status, enable and clear registers
`define EV_GAP 0
`define EV_LOSS 1
`define EV_TMO 2
`define EV_DUP 3
`define EV_RX 4
`define EV_W 5

// retransmission time-out: time in ns, clock period in ns, derived cycle count
`define RTO_NS 4000
`define CLK_NS 4
`define RTO_CYCLES (`RTO_NS / `CLK_NS)

`endif
